// >>> core/fsk_address_code_link.sv
// Address code link: encoder plus tone-keyed decoder with valid one-shot
`timescale 1ns/1ps
// Operation
// RULE_01: Encoder sends sixteen symbols per pattern: one, zero or sync.
// RULE_02: Each symbol lasts 32 high tone periods.
// RULE_03: A full pattern lasts 512 high tone periods.
// RULE_04: Both sides take a 9-bit address; they pair only when equal.
// RULE_05: Three fixed preamble bits are sent and checked with the address.
// RULE_06: Decoder compares each received pattern with its own address.
// RULE_07: Decoder tracks the 20 kHz tone and tolerates 15 percent deviation.
// RULE_08: No valid output before three patterns examined.
// RULE_09: Two 3-bit counters: successive good codes, successive bad codes.
// RULE_10: Three good codes trigger the one-shot and assert valid.
// RULE_11: Three bad codes clear good count, restart one-shot, hold valid off.
// RULE_12: Any good code clears the bad counter.
// RULE_13: A good code while valid retriggers the one-shot.
// RULE_14: Valid has a minimum on-off period of twice the one-shot.
// RULE_15: A one is 32 continuous high tone periods.
// RULE_16: A zero is 16 high tone then 8 low tone periods.
// RULE_17: A sync is 16 low tone periods.
// RULE_18: High tone is oscillator over two, low tone is high over two.
// RULE_19: Good only when preamble and address all match; else bad.
// RULE_20: One-shot length is a cycle count, default about one second.
module fsk_address_code_link #(
  parameter int         ONESHOT_CYC = fsk_pkg::ONESHOT_CYC,
  parameter int         OSC_CYC     = fsk_pkg::OSC_CYC,
  parameter logic [2:0] PREAMBLE    = fsk_pkg::PREAMBLE_DEF
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       enc_key_i,
  input  wire logic [fsk_pkg::ADDR_W-1:0] enc_addr_i,
  input  wire logic [fsk_pkg::ADDR_W-1:0] dec_addr_i,
  input  wire logic                       dec_rx_i,
  output logic                            enc_tx_o,
  output logic                            enc_busy_o,
  output logic                            dec_valid_o,
  output fsk_pkg::fsk_cnt_t               dec_cnt_o
);
  localparam int TW = $clog2(ONESHOT_CYC + 1);
  localparam int THR_S = OSC_CYC * 3 / 2;
  localparam int THR_L = OSC_CYC * 5 / 2;
  localparam int WW = $clog2(THR_L + 1);
  localparam int SW = 2 * fsk_pkg::ADDR_W + 2;
  localparam logic [fsk_pkg::CNT_W-1:0] BAD_TRIG_W = fsk_pkg::BAD_TRIG;

  // Elaboration checks: timers and width classes need room to count
  if (ONESHOT_CYC < 2)
  begin : g_os_chk
    $error("ONESHOT_CYC must be at least 2");
  end
  if (OSC_CYC < 4)
  begin : g_osc_chk
    $error("OSC_CYC must be at least 4");
  end

  typedef enum {FSK_D_HUNT, FSK_D_DATA} fsk_dec_st_t;
  typedef enum {FSK_V_IDLE, FSK_V_ON, FSK_V_HOLD} fsk_val_st_t;

  logic [SW-1:0]                  sync1;
  logic [SW-1:0]                  sync2;
  logic                           key_s;
  logic                           rx_s;
  logic [fsk_pkg::ADDR_W-1:0]     enc_addr_s;
  logic [fsk_pkg::ADDR_W-1:0]     dec_addr_s;
  logic                           rx_prev;
  logic                           edge_ev;
  logic [WW-1:0]                  wcnt;
  logic                           is_short;
  logic                           is_long;
  logic                           gap;
  fsk_dec_st_t                    dst;
  logic [6:0]                     unit;
  logic [6:0]                     next_unit;
  logic                           saw_s;
  logic                           saw_l;
  logic                           next_saw_s;
  logic                           next_saw_l;
  logic                           sym_err;
  logic                           sym_done;
  logic [3:0]                     nsym;
  logic [fsk_pkg::CODE_W-1:0]     shreg;
  logic [fsk_pkg::CODE_W-1:0]     next_shreg;
  logic [6:0]                     lrun;
  logic                           code_good;
  logic                           code_bad;
  fsk_val_st_t                    vst;
  logic [TW-1:0]                  os_cnt;
  logic                           os_end;

  // Pins pass two flops; only the second stage is read
  always_ff @(posedge clk_i)
  begin
    sync1 <= {enc_key_i, dec_rx_i, enc_addr_i, dec_addr_i};
    sync2 <= sync1;
  end
  assign {key_s, rx_s, enc_addr_s, dec_addr_s} = sync2;

  // Transmit side
  fsk_encoder #(
    .OSC_CYC  (OSC_CYC),
    .PREAMBLE (PREAMBLE)
  ) u_enc (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .key_i  (key_s),
    .addr_i (enc_addr_s),
    .tx_o   (enc_tx_o),
    .busy_o (enc_busy_o)
  );

  // Half-period timer, restarted on every received edge
  always_ff @(posedge clk_i)
    if (srst_i)
    begin
      rx_prev <= 1'b0;
      wcnt    <= WW'(THR_L);
    end
    else
    begin
      rx_prev <= rx_s;
      if (edge_ev)
        wcnt <= WW'(1);
      else if (wcnt != WW'(THR_L))
        wcnt <= wcnt + 1'b1;
    end

  // Width classes re-timed on each edge, so drift does not accumulate
  assign edge_ev  = rx_s ^ rx_prev;
  assign is_short = edge_ev && (wcnt < WW'(THR_S));  // see RULE_07
  assign is_long  = edge_ev && !is_short && (wcnt < WW'(THR_L));
  assign gap      = (edge_ev && (wcnt >= WW'(THR_L)))
                 || (!edge_ev && (wcnt == WW'(THR_L - 1)));

  // Symbol slicer: a short half is one unit, a long half two
  always_comb
  begin
    next_unit  = unit + (is_long ? 7'h2 : 7'h1);
    next_saw_s = saw_s || (is_short && unit >= 7'(fsk_pkg::HALF_UNITS));
    next_saw_l = saw_l || (is_long && unit >= 7'(fsk_pkg::HALF_UNITS));
    sym_done   = (is_short || is_long) && next_unit >= 7'(fsk_pkg::SYM_UNITS);
    sym_err    = gap
              || (is_long && unit < 7'(fsk_pkg::HALF_UNITS))
              || (next_unit > 7'(fsk_pkg::SYM_UNITS))
              || (sym_done && (next_saw_s == next_saw_l));
    next_shreg = {shreg[fsk_pkg::CODE_W-2:0], next_saw_s};
  end

  // Frame result: malformed symbol, gap or wrong code counts as bad
  always_comb
  begin
    code_good = 1'b0;
    code_bad  = 1'b0;
    if (dst == FSK_D_DATA)
    begin
      if (sym_err)
        code_bad = 1'b1;                                        // see RULE_19
      else if (sym_done && nsym == 4'(fsk_pkg::CODE_W - 1))
      begin
        if (next_shreg == {PREAMBLE, dec_addr_s})              // see RULE_06
          code_good = 1'b1;                                     // see RULE_19
        else
          code_bad = 1'b1;
      end
    end
  end

  // Frame tracker: a long low-tone run marks the pattern start
  always_ff @(posedge clk_i)
    if (srst_i)
    begin
      dst   <= FSK_D_HUNT;
      lrun  <= '0;
      unit  <= '0;
      saw_s <= 1'b0;
      saw_l <= 1'b0;
      nsym  <= '0;
      shreg <= '0;
    end
    else
    begin
      case (dst)
        FSK_D_HUNT:
        begin
          if (is_long && lrun != 7'h7f)
            lrun <= lrun + 1'b1;
          else if (gap)
            lrun <= '0;
          else if (is_short)
          begin
            lrun <= '0;
            if (lrun >= 7'(fsk_pkg::SYNC_MIN_LONG))            // see RULE_01
            begin
              dst   <= FSK_D_DATA;
              unit  <= 7'h1;
              saw_s <= 1'b0;
              saw_l <= 1'b0;
              nsym  <= '0;
            end
          end
        end
        FSK_D_DATA:
        begin
          if (code_good || code_bad)
          begin
            dst  <= FSK_D_HUNT;
            lrun <= '0;
          end
          else if (sym_done)
          begin
            unit  <= '0;
            saw_s <= 1'b0;
            saw_l <= 1'b0;
            nsym  <= nsym + 1'b1;
            shreg <= next_shreg;                                // see RULE_05
          end
          else if (is_short || is_long)
          begin
            unit  <= next_unit;
            saw_s <= next_saw_s;
            saw_l <= next_saw_l;
          end
        end
        default:
          dst <= FSK_D_HUNT;
      endcase
    end

  // Successive good and bad code counters, saturating at seven
  always_ff @(posedge clk_i)
    if (srst_i)
      dec_cnt_o <= '0;
    else if (code_good)
    begin
      dec_cnt_o.bad <= '0;                                      // see RULE_12
      if (dec_cnt_o.good != '1)
        dec_cnt_o.good <= dec_cnt_o.good + 1'b1;                // see RULE_09
    end
    else if (code_bad)
    begin
      if (dec_cnt_o.bad != '1)
        dec_cnt_o.bad <= dec_cnt_o.bad + 1'b1;                  // see RULE_09
      if (dec_cnt_o.bad >= BAD_TRIG_W - 3'h1)
        dec_cnt_o.good <= '0;                                   // see RULE_11
    end
    else if (os_end && vst == FSK_V_ON)
      dec_cnt_o.good <= '0;

  // One-shot timer shared by the on period and the forced off period
  assign os_end = (os_cnt == TW'(1));
  always_ff @(posedge clk_i)
    if (srst_i)
      os_cnt <= '0;
    else if ((vst == FSK_V_IDLE && code_good
              && dec_cnt_o.good >= fsk_pkg::GOOD_TRIG - 3'h1)   // see RULE_10
          || (vst == FSK_V_ON && code_good)                     // see RULE_13
          || (vst != FSK_V_IDLE && code_bad
              && dec_cnt_o.bad >= BAD_TRIG_W - 3'h1)            // see RULE_11
          || (vst == FSK_V_ON && os_end))                       // see RULE_14
      os_cnt <= TW'(ONESHOT_CYC);                               // see RULE_20
    else if (os_cnt != '0)
      os_cnt <= os_cnt - 1'b1;

  // Valid state: off time after any on period lasts a full one-shot
  always_ff @(posedge clk_i)
    if (srst_i)
      vst <= FSK_V_IDLE;
    else
    begin
      case (vst)
        FSK_V_IDLE:
          if (code_good && dec_cnt_o.good >= fsk_pkg::GOOD_TRIG - 3'h1) // see RULE_08
            vst <= FSK_V_ON;
        FSK_V_ON:
          if (code_bad && dec_cnt_o.bad >= BAD_TRIG_W - 3'h1)
            vst <= FSK_V_HOLD;                                  // see RULE_11
          else if (os_end && !code_good)
            vst <= FSK_V_HOLD;                                  // see RULE_14
        FSK_V_HOLD:
          if (os_end && !(code_bad && dec_cnt_o.bad >= BAD_TRIG_W - 3'h1))
            vst <= FSK_V_IDLE;
        default:
          vst <= FSK_V_IDLE;
      endcase
    end

  // Registered valid pin, high only in the on state
  always_ff @(posedge clk_i)
    if (srst_i)
      dec_valid_o <= 1'b0;
    else
      dec_valid_o <= (vst == FSK_V_ON);
endmodule

// >>> core/fsk_pkg.sv
// Shared constants and types for the address code link
package fsk_pkg;
  // Clock and oscillator rates
  localparam int CLK_HZ        = 40_000_000;
  localparam int OSC_HZ        = 40_000;
  localparam int OSC_CYC       = CLK_HZ / OSC_HZ;
  // Symbol and pattern shape
  localparam int SYM_HF        = 32;
  localparam int SYM_UNITS     = 2 * SYM_HF;
  localparam int HALF_UNITS    = SYM_UNITS / 2;
  localparam int ZERO_HF       = 16;
  localparam int ZERO_LF       = 8;
  localparam int SYNC_LF       = 16;
  localparam int FRAME_SYMS    = 16;
  localparam int FRAME_HF      = 512;
  localparam int SYNC_SYMS     = 4;
  localparam int ADDR_W        = 9;
  localparam int PRE_W         = 3;
  localparam int CODE_W        = ADDR_W + PRE_W;
  localparam logic [2:0] PREAMBLE_DEF = 3'h5;
  // Receive classification thresholds in clock cycles; sync minimum in long halves
  localparam int THR_SHORT     = OSC_CYC * 3 / 2;
  localparam int THR_LONG      = OSC_CYC * 5 / 2;
  localparam int SYNC_MIN_LONG = 48;
  // Good and bad code counting
  localparam int CNT_W         = 3;
  localparam logic [2:0] GOOD_TRIG = 3'h3;
  localparam logic [2:0] BAD_TRIG  = 3'h3;
  // One-shot period
  localparam int ONESHOT_MS    = 1000;
  localparam int ONESHOT_CYC   = (CLK_HZ / 1000) * ONESHOT_MS;

  typedef struct packed {
    logic [CNT_W-1:0] good;
    logic [CNT_W-1:0] bad;
  } fsk_cnt_t;

  typedef enum {FSK_SYM_SYNC, FSK_SYM_ONE, FSK_SYM_ZERO} fsk_sym_t;
endpackage

// >>> core/fsk_encoder.sv
// Pattern encoder: sync run, preamble and address as tone-keyed symbols
`timescale 1ns/1ps
module fsk_encoder #(
  parameter logic [2:0] PREAMBLE = fsk_pkg::PREAMBLE_DEF,
  parameter int         OSC_CYC  = fsk_pkg::OSC_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       key_i,
  input  wire logic [fsk_pkg::ADDR_W-1:0] addr_i,
  output logic                            tx_o,
  output logic                            busy_o
);
  localparam int OW = $clog2(OSC_CYC);

  // Tick counter needs at least two states
  if (OSC_CYC < 2)
  begin : g_osc_chk
    $error("OSC_CYC must be at least 2");
  end

  logic [OW-1:0]                  osc_cnt;
  logic                           tick;
  logic [1:0]                     div;
  logic [5:0]                     slot;
  logic [3:0]                     idx;
  logic [fsk_pkg::CODE_W-1:0]     code;
  fsk_pkg::fsk_sym_t              kind;
  logic                           level;
  logic                           last;

  // Oscillator stand-in: one tick per oscillator period
  assign tick = (osc_cnt == OW'(OSC_CYC - 1));
  always_ff @(posedge clk_i)
    if (srst_i || !busy_o)
      osc_cnt <= '0;
    else
      osc_cnt <= tick ? '0 : osc_cnt + 1'b1;

  assign last = tick && (slot == 6'h3f) && (idx == 4'hf);

  // Patterns are always sent whole; key released only stops at the end
  always_ff @(posedge clk_i)
    if (srst_i)
      busy_o <= 1'b0;
    else if (!busy_o)
      busy_o <= key_i;
    else if (last)
      busy_o <= key_i;

  // Tone dividers and symbol position, two oscillator ticks per high tone cycle
  always_ff @(posedge clk_i)
    if (srst_i || !busy_o)
    begin
      div  <= '0;
      slot <= '0;
      idx  <= '0;
    end
    else if (tick)
    begin
      div  <= div + 1'b1;                   // see RULE_18
      slot <= slot + 1'b1;                  // see RULE_02
      if (slot == 6'h3f)
        idx <= idx + 1'b1;                  // see RULE_03
    end

  // Address caught at each pattern start so it cannot change mid-pattern
  always_ff @(posedge clk_i)
    if (srst_i)
      code <= '0;
    else if ((!busy_o && key_i) || last)
      code <= {PREAMBLE, addr_i};           // see RULE_04, see RULE_05

  // Symbol kind: sync run first, then preamble and address MSB first
  always_comb
  begin
    if (idx < 4'(fsk_pkg::SYNC_SYMS))
      kind = fsk_pkg::FSK_SYM_SYNC;
    else if (code[4'(fsk_pkg::CODE_W - 1) - (idx - 4'(fsk_pkg::SYNC_SYMS))])
      kind = fsk_pkg::FSK_SYM_ONE;
    else
      kind = fsk_pkg::FSK_SYM_ZERO;
  end

  // Tone select: high tone is div[0], low tone is div[1]
  always_comb
  begin
    case (kind)
      fsk_pkg::FSK_SYM_SYNC: level = div[1];                  // see RULE_17
      fsk_pkg::FSK_SYM_ONE:  level = div[0];                  // see RULE_15
      fsk_pkg::FSK_SYM_ZERO: level = slot[5] ? div[1] : div[0]; // see RULE_16
      default:               level = 1'b0;
    endcase
  end

  // Line idles low between patterns
  always_ff @(posedge clk_i)
    if (srst_i)
      tx_o <= 1'b0;
    else
      tx_o <= busy_o && level;              // see RULE_01
endmodule

// >>> verification/fsk_link_asserts.sv
// Port checker for the address code link, bound to its top module
`timescale 1ns/1ps
module fsk_link_asserts #(
  parameter int ONESHOT_CYC = fsk_pkg::ONESHOT_CYC,
  parameter int OSC_CYC     = fsk_pkg::OSC_CYC
) (
  input wire logic                       clk_i,
  input wire logic                       srst_i,
  input wire logic                       enc_key_i,
  input wire logic [fsk_pkg::ADDR_W-1:0] enc_addr_i,
  input wire logic [fsk_pkg::ADDR_W-1:0] dec_addr_i,
  input wire logic                       dec_rx_i,
  input wire logic                       enc_tx_o,
  input wire logic                       enc_busy_o,
  input wire logic                       dec_valid_o,
  input wire fsk_pkg::fsk_cnt_t          dec_cnt_o
);
  localparam int PAT_CYC = fsk_pkg::FRAME_HF * 2 * OSC_CYC;
  logic [31:0] hold_cnt;
  logic [31:0] busy_cnt;
  logic [31:0] off_cnt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // Cycles since the tone output last moved
  always_ff @(posedge clk_i)
  begin
    if (srst_i || $changed(enc_tx_o))
      hold_cnt <= 32'h0;
    else
      hold_cnt <= hold_cnt + 32'h1;
  end

  // Length of the current busy run
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !enc_busy_o)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy_cnt + 32'h1;
  end

  // Low time of valid; starts saturated so the first rise is legal
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      off_cnt <= 32'hffffffff;
    else if (dec_valid_o)
      off_cnt <= 32'h0;
    else if (off_cnt != 32'hffffffff)
      off_cnt <= off_cnt + 32'h1;
  end

  property p_tone_step;
    $changed(enc_tx_o) |-> hold_cnt >= 32'(OSC_CYC - 1);
  endproperty
  a_tone_step: assert property (p_tone_step) else $error("tone edge too soon");

  property p_pat_len;
    $fell(enc_busy_o) |-> busy_cnt != 32'h0 && busy_cnt % PAT_CYC == 0;
  endproperty
  a_pat_len: assert property (p_pat_len) else $error("pattern length wrong");

  property p_three_first;
    $rose(dec_valid_o) |-> dec_cnt_o.good >= 3'h3;
  endproperty
  a_three_first: assert property (p_three_first) else $error("valid too early");

  property p_good_clears;
    $changed(dec_cnt_o.good) && dec_cnt_o.good != 3'h0 |-> dec_cnt_o.bad == 3'h0;
  endproperty
  a_good_clears: assert property (p_good_clears) else $error("bad not cleared");

  property p_good_step;
    $changed(dec_cnt_o.good) && dec_cnt_o.good != 3'h0
      |-> dec_cnt_o.good == $past(dec_cnt_o.good) + 3'h1;
  endproperty
  a_good_step: assert property (p_good_step) else $error("good count jump");

  property p_bad_step;
    $changed(dec_cnt_o.bad) && dec_cnt_o.bad != 3'h0
      |-> dec_cnt_o.bad == $past(dec_cnt_o.bad) + 3'h1;
  endproperty
  a_bad_step: assert property (p_bad_step) else $error("bad count jump");

  property p_bad_clears;
    dec_cnt_o.bad >= 3'h3 |-> dec_cnt_o.good == 3'h0;
  endproperty
  a_bad_clears: assert property (p_bad_clears) else $error("good not cleared");

  property p_bad_off;
    dec_cnt_o.bad >= 3'h3 |=> !dec_valid_o;
  endproperty
  a_bad_off: assert property (p_bad_off) else $error("valid on after bad run");

  property p_min_off;
    $rose(dec_valid_o) |-> off_cnt >= 32'(ONESHOT_CYC - 2);
  endproperty
  a_min_off: assert property (p_min_off) else $error("valid off time short");
endmodule

bind fsk_address_code_link fsk_link_asserts #(
  .ONESHOT_CYC (ONESHOT_CYC),
  .OSC_CYC     (OSC_CYC)
) u_chk (
  .clk_i       (clk_i),
  .srst_i      (srst_i),
  .enc_key_i   (enc_key_i),
  .enc_addr_i  (enc_addr_i),
  .dec_addr_i  (dec_addr_i),
  .dec_rx_i    (dec_rx_i),
  .enc_tx_o    (enc_tx_o),
  .enc_busy_o  (enc_busy_o),
  .dec_valid_o (dec_valid_o),
  .dec_cnt_o   (dec_cnt_o)
);

// >>> verification/fsk_tone_src.sv
// Far-side transmitter model feeding tone-keyed patterns to the decoder
`timescale 1ns/1ps
module fsk_tone_src (
  input  wire logic clk_i,
  output logic      rx_o
);
  initial rx_o = 1'b0;

  // Line level at tick t of a pattern; four sync symbols, then code MSB first
  function automatic logic tone(input logic [11:0] code, input int t);
    int w;
    w = t % 64;
    if (t < 256)
      return w[1];
    if (code[15 - t / 64] || w < 32)
      return w[0];
    return w[1];
  endfunction

  // Whole pattern; tick sets the far oscillator period, so drift varies per call
  task automatic send(input logic [11:0] code, input int tick);
    int t;
    for (t = 0; t < 1024; t++)
    begin
      rx_o = tone(code, t);
      repeat (tick) @(negedge clk_i);
    end
  endtask

  // Carrier gone: line parks away from its last level
  task automatic quiet;
    rx_o = ~rx_o;
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench: encoder waveform and decoder code counting
`timescale 1ns/1ps
module tb_top;
  // One-shot outlasts three patterns at the slowest far-side drift
  localparam int         OS          = 30_000;
  // Short oscillator period keeps a pattern near 8k cycles
  localparam int         OSC         = 8;
  localparam logic [6:0] EXP_SEQ [7] = '{7'h08, 7'h10, 7'h58, 7'h59, 7'h5a, 7'h03, 7'h08};
  logic                       clk_i;
  logic                       srst_i;
  logic                       enc_key_i;
  logic [fsk_pkg::ADDR_W-1:0] enc_addr_i;
  logic [fsk_pkg::ADDR_W-1:0] dec_addr_i;
  logic                       dec_rx_i;
  logic                       enc_tx_o;
  logic                       enc_busy_o;
  logic                       dec_valid_o;
  fsk_pkg::fsk_cnt_t          dec_cnt_o;
  fsk_pkg::fsk_cnt_t          prev_cnt;
  logic [6:0]                 exp_q [$];
  logic [6:0]                 note;
  logic                       exp_v;
  int                         vwait;
  int                         fails;
  int                         checks_done;

  fsk_address_code_link #(
    .ONESHOT_CYC (OS),
    .OSC_CYC     (OSC)
  ) DUT (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .enc_key_i   (enc_key_i),
    .enc_addr_i  (enc_addr_i),
    .dec_addr_i  (dec_addr_i),
    .dec_rx_i    (dec_rx_i),
    .enc_tx_o    (enc_tx_o),
    .enc_busy_o  (enc_busy_o),
    .dec_valid_o (dec_valid_o),
    .dec_cnt_o   (dec_cnt_o)
  );

  fsk_tone_src u_src (
    .clk_i (clk_i),
    .rx_o  (dec_rx_i)
  );

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Worst drift needs about 75k cycles; cut off at 100k
  initial
  begin
    repeat (100_000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  // Each counter change takes the oldest note; valid is judged three cycles on
  always @(negedge clk_i)
  begin
    if (vwait == 1)
      check(12'(dec_valid_o), 12'(exp_v));
    if (vwait > 0)
      vwait--;
    if (!srst_i && dec_cnt_o !== prev_cnt)
    begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 7'h7f;
      check(12'(dec_cnt_o), 12'(note[5:0]));
      exp_v = note[6];
      vwait = 3;
    end
    prev_cnt = dec_cnt_o;
  end

  // One keyed pattern; key drops and address flips early but must not cut it short
  task automatic enc_run;
    logic [11:0] code;
    int          t;
    code = {fsk_pkg::PREAMBLE_DEF, enc_addr_i};
    enc_key_i = 1'b1;
    for (t = 0; t < 8 && enc_busy_o !== 1'b1; t++)
      @(negedge clk_i);
    repeat (OSC / 2) @(posedge clk_i);
    for (t = 0; t < 1024; t++)
    begin
      @(negedge clk_i);
      if (t == 10)
      begin
        enc_key_i = 1'b0;
        enc_addr_i = ~enc_addr_i;
      end
      check(12'({enc_busy_o, enc_tx_o}), 12'({1'b1, u_src.tone(code, t)}));
      repeat (OSC) @(posedge clk_i);
    end
    repeat (OSC) @(posedge clk_i);
    @(negedge clk_i);
    check(12'({enc_busy_o, enc_tx_o}), 12'h000);
  endtask

  // Three good, bad preamble, two bad addresses, then a good one inside hold-off
  task automatic dec_run;
    logic [11:0] good;
    logic [11:0] code;
    int          i;
    good = {fsk_pkg::PREAMBLE_DEF, dec_addr_i};
    for (i = 0; i < 7; i++)
    begin
      code = good;
      if (i == 3)
        code = good ^ 12'h800;
      if (i == 4 || i == 5)
        code = good ^ (12'h001 << $urandom_range(8, 0));
      exp_q.push_back(EXP_SEQ[i]);
      u_src.send(code, $urandom_range(OSC + OSC / 8, OSC - OSC / 8));
    end
    u_src.quiet();
    repeat (10000) @(negedge clk_i);
    check(12'(exp_q.size()), 12'h000);
  endtask

  initial
  begin
    srst_i = 1'b1;
    enc_key_i = 1'b0;
    enc_addr_i = 9'($urandom(32'heb6585c6));
    dec_addr_i = 9'($urandom());
    vwait = 0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    fork
      enc_run();
      dec_run();
    join
    report_and_stop();
  end
endmodule
